// >>> design/sfpf_front_end.v
`timescale 1ns/10ps
`include "sfpf_defines.vh"
module sfpf_front_end #(
    parameter RESET_CYC = `SFPF_RESET_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Link pins
    input wire sclkIn,
    input wire selectN,
    input wire [3:0] laneIn,
    output reg [3:0] laneOut,
    output reg [3:0] laneOe,
    // Mode from core: 0 single, 1 dual, 2 quad
    input wire [1:0] busWidth,
    input wire driveData,
    input wire [3:0] txNibble,
    // Status bytes and protection
    input wire [7:0] statusByteOne,
    input wire [7:0] statusByteTwo,
    input wire pauseOrResetSelect,
    input wire internalBusy,
    input wire addrGuarded,
    input wire statusWriteReq,
    input wire arrayWriteReq,
    // Core side outputs
    output reg [7:0] rxShift_reg,
    output reg [7:0] bitCount_reg,
    output reg rxStrobe,
    output reg txShiftStrobe,
    output reg armed_reg,
    output reg standbyMode,
    output reg holdActive_reg,
    output reg deviceResetPulse,
    output reg statusWriteRefused,
    output reg arrayWriteRefused,
    output reg [10:0] sectorNum,
    output reg [7:0] halfBlockNum,
    output reg [6:0] blockNum,
    output reg [2:0] bigBlockNum,
    input wire [`SFPF_ADDR_W-1:0] decodeAddr
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    wire [5:0] syncPins;
    sfpf_sync2 #(.WIDTH(6)) uSync (
        .clk(clk),
        .rstn(rstn),
        .asyncIn({sclkIn, selectN, laneIn}),
        .syncOut(syncPins)
    );
    wire sclkS = syncPins[5];
    wire selNS = syncPins[4];
    wire [3:0] laneS = syncPins[3:0];
    reg sclkD_reg;
    reg selD_reg;
    // Delay flops reset to the synchroniser's reset level, so no false edge after reset
    always @(posedge clk) begin
        if (!rstn) begin
            sclkD_reg <= 1'b1;
            selD_reg <= 1'b1;
        end else begin
            sclkD_reg <= sclkS;
            selD_reg <= selNS;
        end
    end
    // Edge detection works for either idle level of the clock
    wire sclkRise = sclkS & ~sclkD_reg;
    wire sclkFall = ~sclkS & sclkD_reg;
    wire selFall = ~selNS & selD_reg;

    // ************************************************
    // Pin function selection
    // ************************************************
    wire quadOn = statusByteTwo[`SFPF_SR2_QUAD];
    wire holdMode = ~quadOn & ~pauseOrResetSelect;
    wire resetMode = ~quadOn & pauseOrResetSelect;
    wire guardLow = ~quadOn & ~laneS[2];
    wire hwLock = guardLow & ~statusByteTwo[`SFPF_SR2_LOCK1] & statusByteOne[`SFPF_SR1_LOCK0];

    // ************************************************
    // Hardware reset on pin four
    // ************************************************
    localparam [31:0] RST_LAST = RESET_CYC - 1;
    reg [15:0] rstCnt_reg;
    reg rstFired_reg;
    wire pinReset = resetMode & ~laneS[3];
    always @(posedge clk) begin
        if (!rstn) begin
            rstCnt_reg <= 16'h0000;
            rstFired_reg <= 1'b0;
            deviceResetPulse <= 1'b0;
        end else begin
            deviceResetPulse <= 1'b0;
            if (!pinReset) begin
                rstCnt_reg <= 16'h0000;
                rstFired_reg <= 1'b0;
            end else if ({16'h0000, rstCnt_reg} < RST_LAST) begin
                rstCnt_reg <= rstCnt_reg + 16'h0001;
            end else if (!rstFired_reg) begin
                rstFired_reg <= 1'b1; // Pulse long enough
                deviceResetPulse <= 1'b1;
            end
        end
    end
    wire inReset = pinReset | rstFired_reg;

    // ************************************************
    // Hold tracking
    // ************************************************
    // Hold state follows pin four only while the clock is low; deselect or leaving hold mode clears it at once
    reg holdNext;
    always @* begin
        holdNext = holdActive_reg;
        if (!holdMode || selNS) begin
            holdNext = 1'b0;
        end else if (!sclkS) begin
            holdNext = ~laneS[3];
        end
    end
    always @(posedge clk) begin
        if (!rstn) begin
            holdActive_reg <= 1'b0;
        end else begin
            holdActive_reg <= holdNext;
        end
    end
    wire linkLive = armed_reg & ~selNS & ~holdActive_reg & ~inReset;

    // ************************************************
    // Arming, power mode, shifter
    // ************************************************
    reg [3:0] nibble;
    always @* begin
        case (busWidth)
            2'b00: nibble = {3'b000, laneS[0]};
            2'b01: nibble = {2'b00, laneS[1:0]};
            2'b10: nibble = laneS;
            default: nibble = {3'b000, laneS[0]};
        endcase
    end
    always @(posedge clk) begin
        if (!rstn || deviceResetPulse) begin
            armed_reg <= 1'b0;
            standbyMode <= 1'b1;
            rxShift_reg <= 8'h00;
            bitCount_reg <= 8'h00;
            rxStrobe <= 1'b0;
            txShiftStrobe <= 1'b0;
        end else begin
            rxStrobe <= 1'b0;
            txShiftStrobe <= 1'b0;
            standbyMode <= selNS & ~internalBusy;
            if (selFall) begin
                armed_reg <= 1'b1;
            end
            if (selNS) begin
                rxShift_reg <= 8'h00;
                bitCount_reg <= 8'h00;
            end else if (linkLive && sclkRise) begin
                rxStrobe <= 1'b1;
                bitCount_reg <= bitCount_reg + 8'h01;
                case (busWidth)
                    2'b01: rxShift_reg <= {rxShift_reg[5:0], nibble[1:0]};
                    2'b10: rxShift_reg <= {rxShift_reg[3:0], nibble};
                    default: rxShift_reg <= {rxShift_reg[6:0], nibble[0]};
                endcase
            end else if (linkLive && sclkFall) begin
                txShiftStrobe <= 1'b1;
            end
        end
    end

    // ************************************************
    // Output lanes
    // ************************************************
    always @(posedge clk) begin
        if (!rstn) begin
            laneOut <= 4'h0;
            laneOe <= 4'h0;
        end else if (!linkLive || !driveData) begin
            laneOe <= 4'h0;
        end else if (sclkFall) begin
            laneOut <= txNibble;
            case (busWidth)
                2'b01: laneOe <= 4'h3;
                2'b10: laneOe <= 4'hF;
                default: laneOe <= 4'h2;
            endcase
        end
    end

    // ************************************************
    // Protection and address decode
    // ************************************************
    always @(posedge clk) begin
        if (!rstn) begin
            statusWriteRefused <= 1'b0;
            arrayWriteRefused <= 1'b0;
            sectorNum <= 11'h000;
            halfBlockNum <= 8'h00;
            blockNum <= 7'h00;
            bigBlockNum <= 3'h0;
        end else begin
            statusWriteRefused <= statusWriteReq & hwLock;
            arrayWriteRefused <= arrayWriteReq & hwLock & addrGuarded;
            sectorNum <= decodeAddr[22:`SFPF_SECTOR_LSB];
            halfBlockNum <= decodeAddr[22:`SFPF_HALF_LSB];
            blockNum <= decodeAddr[22:`SFPF_BLOCK_LSB];
            bigBlockNum <= decodeAddr[22:`SFPF_BIG_LSB];
        end
    end
endmodule // sfpf_front_end

// >>> design/sfpf_defines.vh
`ifndef SFPF_DEFINES_VH
`define SFPF_DEFINES_VH
`define SFPF_CLK_HZ 20000000
`define SFPF_RESET_MIN_NS 1000
`define SFPF_RESET_CYC ((`SFPF_RESET_MIN_NS * (`SFPF_CLK_HZ / 1000000) + 999) / 1000)
`define SFPF_ADDR_W 24
`define SFPF_SECTOR_LSB 12
`define SFPF_HALF_LSB 15
`define SFPF_BLOCK_LSB 16
`define SFPF_BIG_LSB 20
`define SFPF_SR1_LOCK0 7
`define SFPF_SR2_LOCK1 0
`define SFPF_SR2_QUAD 1
`endif

// >>> design/sfpf_sync2.v
`timescale 1ns/10ps
module sfpf_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Data
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    always @(posedge clk) begin
        if (!rstn) begin
            stage1_reg <= {WIDTH{1'b1}};
            syncOut <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule // sfpf_sync2

// >>> dv/sfpf_front_end_props.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module sfpf_front_end_props(
    input wire clk, rstn, selectN, internalBusy, standbyMode, armed_reg, rxStrobe,
    input wire statusWriteReq, statusWriteRefused, arrayWriteReq, addrGuarded, arrayWriteRefused,
    input wire [3:0] laneIn, laneOe,
    input wire [7:0] statusByteOne, statusByteTwo,
    input wire [23:0] decodeAddr,
    input wire [10:0] sectorNum,
    input wire [6:0] blockNum
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Guard pin must sit still through the sync delay
    wire lk = !laneIn[2] && statusByteOne[7] && !statusByteTwo[0] && !statusByteTwo[1];
    property p_float; selectN && $past(selectN, 4) |-> laneOe == 4'h0; endproperty
    a_float: assert property (p_float) else $error("lanes driven deselected");
    property p_standby; (selectN && !internalBusy) [*6] |-> standbyMode; endproperty
    a_standby: assert property (p_standby) else $error("no standby");
    property p_noArm; !armed_reg |-> !rxStrobe; endproperty
    a_noArm: assert property (p_noArm) else $error("decode before select fall");
    property p_pulse; rxStrobe |=> !rxStrobe; endproperty
    a_pulse: assert property (p_pulse) else $error("sample strobe too long");
    property p_slock; lk && $past(lk, 4) && statusWriteReq |=> statusWriteRefused; endproperty
    a_slock: assert property (p_slock) else $error("status write let through");
    property p_alock; lk && $past(lk, 4) && arrayWriteReq && addrGuarded |=> arrayWriteRefused; endproperty
    a_alock: assert property (p_alock) else $error("array write let through");
    property p_sector; $past(rstn) |-> sectorNum == $past(decodeAddr[22:12]); endproperty
    a_sector: assert property (p_sector) else $error("sector decode");
    property p_block; $past(rstn) |-> blockNum == $past(decodeAddr[22:16]); endproperty
    a_block: assert property (p_block) else $error("block decode");
    c_rx: cover property (rxStrobe);
    c_lock: cover property (statusWriteRefused);
    c_sleep: cover property ($rose(standbyMode));
endmodule // sfpf_front_end_props
bind sfpf_front_end sfpf_front_end_props i_sfpf_front_end_props (.*);

// >>> dv/sfpf_host_model.sv
`timescale 1ns/10ps
// ****
// Host side of the link
// ****
module sfpf_host_model(
    input wire clk,
    output reg sclk,
    output reg selN,
    output reg [3:0] lanes
);
    integer i;
    initial begin
        sclk = 1'b0;
        selN = 1'b1;
        lanes = 4'hF;
    end
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Data set while clock low, held across the rise
    task xfer(input [7:0] d, input integer w, input idle);
        begin
            sclk = idle;
            tick(4);
            selN = 1'b0;
            tick(4);
            for (i = 8 - w; i >= 0; i = i - w) begin
                sclk = 1'b0;
                lanes = (w == 4) ? d[i+:4] : {2'b11, (w == 2) ? d[i+:2] : {~lanes[1], d[i]}};
                tick(4);
                sclk = 1'b1;
                tick(4);
            end
            sclk = idle;
            tick(4);
        end
    endtask
    // Released lines must not show a stale value
    task endf;
        begin
            selN = 1'b1;
            lanes = {2'b11, ~lanes[1:0]};
            tick(6);
        end
    endtask
endmodule // sfpf_host_model

// >>> dv/serial_flash_pin_front_end_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module serial_flash_pin_front_end_tb;
    reg clk = 1'b0, rstn = 1'b0, driveData = 1'b1, pauseOrResetSelect = 1'b0, internalBusy = 1'b0;
    reg addrGuarded = 1'b0, statusWriteReq = 1'b0, arrayWriteReq = 1'b0;
    reg [1:0] busWidth = 2'h0;
    reg [3:0] txNibble = 4'h0;
    reg [7:0] statusByteOne = 8'h00, statusByteTwo = 8'h00, d = 8'h00;
    reg [23:0] decodeAddr = 24'h000000;
    reg [31:0] seed = 32'h1EDE;
    wire sclkIn, selectN, rxStrobe, txShiftStrobe, armed_reg, standbyMode, holdActive_reg;
    wire deviceResetPulse, statusWriteRefused, arrayWriteRefused;
    wire [3:0] hostLanes, laneIn, laneOut, laneOe;
    wire [7:0] rxShift_reg, bitCount_reg, halfBlockNum;
    wire [10:0] sectorNum;
    wire [6:0] blockNum;
    wire [2:0] bigBlockNum;
    integer n_errors = 0, compares = 0, k, w, i;
    int q[$];
    always #25 clk = ~clk;
    // ****
    // Pins and instances
    // ****
    assign laneIn = (laneOe & laneOut) | (~laneOe & hostLanes);
    sfpf_front_end #(.RESET_CYC(4)) i_sfpf_front_end (.*);
    sfpf_host_model i_sfpf_host_model (.clk(clk), .sclk(sclkIn), .selN(selectN), .lanes(hostLanes));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d n_errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        tick(3);
        rstn = 1'b1;
        tick(3);
        `CHK(armed_reg, 1'b0)
        for (k = 0; k < 6; k++) begin
            w = 1 << (k % 3);
            seed = lfsr(seed);
            d = seed[7:0];
            txNibble = seed[11:8];
            busWidth = w[2:1];
            statusByteTwo = {6'h00, w[2], 1'b0};
            // Drive only in single mode, where lane one is not sampled
            driveData = (w == 1);
            q.push_back(d);
            i_sfpf_host_model.xfer(d, w, k[0]);
            tick(4);
            `CHK(rxShift_reg, q.pop_front())
            if (w == 1) begin
                `CHK(laneOe, 4'h2)
                `CHK(laneOut, txNibble)
            end
            i_sfpf_host_model.endf;
            `CHK(bitCount_reg, 8'h00)
            `CHK(laneOe, 4'h0)
            `CHK(standbyMode, 1'b1)
        end
        internalBusy = 1'b1;
        tick(6);
        `CHK(standbyMode, 1'b0)
        internalBusy = 1'b0;
        {statusWriteReq, arrayWriteReq, addrGuarded} = 3'h7;
        for (k = 0; k < 16; k++) begin
            statusByteOne = {k[0], 7'h00};
            statusByteTwo = {6'h00, k[3], k[1]};
            i_sfpf_host_model.lanes[2] = k[2];
            tick(6);
            `CHK(statusWriteRefused, k == 1)
            `CHK(arrayWriteRefused, k == 1)
        end
        {statusWriteReq, arrayWriteReq, statusByteTwo} = 10'h000;
        i_sfpf_host_model.lanes[2] = 1'b1;
        for (k = 0; k < 9; k++) begin
            seed = lfsr(seed);
            decodeAddr = (k == 8) ? 24'h7FFFFF : {1'b0, seed[22:0]};
            tick(2);
            `CHK(sectorNum, decodeAddr / 24'h001000)
            `CHK(blockNum, decodeAddr / 24'h010000)
            `CHK(halfBlockNum, decodeAddr / 24'h008000)
            `CHK(bigBlockNum, decodeAddr / 24'h100000)
        end
        // Hold with clock low, release deferred while clock high
        driveData = 1'b1;
        i_sfpf_host_model.sclk = 1'b0;
        i_sfpf_host_model.selN = 1'b0;
        tick(4);
        i_sfpf_host_model.lanes[3] = 1'b0;
        tick(6);
        `CHK(holdActive_reg, 1'b1)
        `CHK(laneOe, 4'h0)
        i_sfpf_host_model.sclk = 1'b1;
        i_sfpf_host_model.lanes[3] = 1'b1;
        tick(6);
        `CHK(holdActive_reg, 1'b1)
        i_sfpf_host_model.sclk = 1'b0;
        tick(6);
        `CHK(holdActive_reg, 1'b0)
        i_sfpf_host_model.endf;
        // Short low pulse must not reset, long one must
        pauseOrResetSelect = 1'b1;
        for (k = 0; k < 2; k++) begin
            w = 0;
            i_sfpf_host_model.lanes[3] = 1'b0;
            for (i = 0; i < 20; i++) begin
                if (i == (k ? 12 : 2)) i_sfpf_host_model.lanes[3] = 1'b1;
                tick(1);
                w = w | deviceResetPulse;
            end
            `CHK(w, k)
        end
        tally_and_finish;
    end
endmodule // serial_flash_pin_front_end_tb
